/* File: logic/cir_cache_ident.sv */
`timescale 1ns/10ps
// What this block does
// [RULE1] Size read reports the currently selected cache
// [RULE2] Bit 31 flags write-through support
// [RULE3] Bit 30 flags write-back support
// [RULE4] Bit 29 flags read-allocation support
// [RULE5] Bit 28 flags write-allocation support
// [RULE6] Set count code follows configured size
// [RULE7] Associativity field reads four ways
// [RULE8] Line length field reads eight words
// [RULE9] Instruction cache capabilities read 0010
// [RULE10] Data cache capabilities read 0111
// [RULE11] Unification and coherency levels read one
// [RULE12] Level one split, higher levels empty
// [RULE13] Auxiliary identification reads as zero
// [RULE14] Selection level field reads zero, ignored
// [RULE15] Selection bit zero picks data/instruction
// [RULE16] Selection register banked per security state
// [RULE17] Identification registers shared by both states
// [RULE18] Access only from privileged modes
// [RULE19] Selection read/write, identification read only
// [RULE20] Unprivileged access raises undefined instruction
// [RULE21] Reserved bits read as zero
module cir_cache_ident #(
	parameter int ICACHE_KB = cir_pkg::CIR_DEFAULT_CACHE_KB,
	parameter int DCACHE_KB = cir_pkg::CIR_DEFAULT_CACHE_KB
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic acc_valid_i,
	input wire logic acc_write_i,
	input wire logic [2:0] acc_opc1_i,
	input wire logic [3:0] acc_crn_i,
	input wire logic [3:0] acc_crm_i,
	input wire logic [2:0] acc_opc2_i,
	input wire logic [31:0] acc_wdata_i,
	input wire logic acc_priv_i,
	input wire logic acc_secure_i,
	output logic acc_done_o,
	output logic acc_undef_o,
	output logic [31:0] acc_rdata_o
);

	// ==========================================================
	// Declarations
	// ==========================================================
	cir_pkg::cir_reg_t target;
	logic legal;
	logic sel_wr_en;
	logic sel_secure;
	logic sel_nonsec;
	logic cur_sel;
	logic [31:0] size_id;
	logic next_done;
	logic next_undef;
	logic [31:0] next_rdata;

	// ==========================================================
	// Access decode
	// ==========================================================
	always_comb begin
		// Unknown selector combinations decode to none and are refused
		target = cir_pkg::cir_decode(acc_opc1_i, acc_crn_i, acc_crm_i, acc_opc2_i);
		legal = 1'b0;
		// [RULE18] privileged access only
		if (acc_priv_i) begin
			// [RULE19] only selection register takes writes
			unique case (target)
				cir_pkg::CIR_REG_SIZE,
				cir_pkg::CIR_REG_LEVEL,
				cir_pkg::CIR_REG_AUX: legal = !acc_write_i;
				cir_pkg::CIR_REG_SELECT: legal = 1'b1;
				cir_pkg::CIR_REG_NONE: legal = 1'b0;
			endcase
		end
		// [RULE15] software writes the selection bit
		sel_wr_en = acc_valid_i && legal && acc_write_i && target == cir_pkg::CIR_REG_SELECT;
	end

	// ==========================================================
	// Selection register and size encoder
	// ==========================================================
	// A refused write never reaches the bank, so no copy moves
	// [RULE16] banked copy per security state
	cir_select_bank u_bank (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.wr_en_i(sel_wr_en),
		.secure_i(acc_secure_i),
		.wr_sel_i(acc_wdata_i[cir_pkg::CIR_SELECT_BIT]),
		.sel_secure_o(sel_secure),
		.sel_nonsec_o(sel_nonsec),
		.cur_sel_o(cur_sel)
	);

	// [RULE1] size word follows current selection
	cir_size_encode #(
		.ICACHE_KB(ICACHE_KB),
		.DCACHE_KB(DCACHE_KB)
	) u_size (
		.instr_sel_i(cur_sel),
		.size_id_o(size_id)
	);

	// ==========================================================
	// Answer
	// ==========================================================
	// Next answer: one cycle after each access, zero data otherwise
	// Data stays zero outside answers so no stale word looks like a reply
	always_comb begin
		next_done = acc_valid_i;
		next_undef = 1'b0;
		next_rdata = 32'h00000000;
		if (acc_valid_i) begin
			if (!legal) begin
				// [RULE20] no data, no state change
				next_undef = 1'b1;
			end else if (!acc_write_i) begin
				// [RULE17] level and aux words shared by both states; size and selection reads follow the current state's copy
				unique case (target)
					cir_pkg::CIR_REG_SIZE: next_rdata = size_id;
					// [RULE11] [RULE12] constant level word
					cir_pkg::CIR_REG_LEVEL: next_rdata = cir_pkg::CIR_LEVEL_ID_VALUE;
					// [RULE13] unused auxiliary word
					cir_pkg::CIR_REG_AUX: next_rdata = cir_pkg::CIR_AUX_ID_VALUE;
					// [RULE14] [RULE21] only bit zero reads back
					cir_pkg::CIR_REG_SELECT: next_rdata = {31'h00000000, cur_sel};
					cir_pkg::CIR_REG_NONE: next_rdata = 32'h00000000;
				endcase
			end
		end
	end

	// Answer registers
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			acc_done_o <= 1'b0;
			acc_undef_o <= 1'b0;
			acc_rdata_o <= 32'h00000000;
		end else begin
			acc_done_o <= next_done;
			acc_undef_o <= next_undef;
			acc_rdata_o <= next_rdata;
		end
	end

	// ==========================================================
	// Assertions
	// ==========================================================
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	// Privileged read of one register
	sequence seq_read(cir_pkg::cir_reg_t r);
		acc_valid_i && acc_priv_i && !acc_write_i && target == r;
	endsequence

	// Privileged write of the selection register
	sequence seq_sel_write;
		acc_valid_i && acc_priv_i && acc_write_i && target == cir_pkg::CIR_REG_SELECT;
	endsequence

	// Answer given with no error
	sequence seq_good_answer;
		acc_done_o && !acc_undef_o;
	endsequence

	// Selection write followed at once by a read in the same state
	sequence seq_write_read;
		seq_sel_write ##1 seq_read(cir_pkg::CIR_REG_SELECT) ##0 $stable(acc_secure_i);
	endsequence

	// [RULE1] size read matches selection
	chk_size_follow: assert property (seq_read(cir_pkg::CIR_REG_SIZE) |=> // [RULE1]
		seq_good_answer ##0 acc_rdata_o == $past(size_id))
		else $error("size word does not follow selection");

	// [RULE9] instruction capabilities
	chk_caps_instr: assert property (seq_read(cir_pkg::CIR_REG_SIZE) and cur_sel |=> // [RULE9]
		acc_rdata_o[31:28] == 4'h2)
		else $error("instruction capability bits wrong");

	// [RULE10] data capabilities
	chk_caps_data: assert property (seq_read(cir_pkg::CIR_REG_SIZE) and !cur_sel |=> // [RULE10]
		acc_rdata_o[31:28] == 4'h7)
		else $error("data capability bits wrong");

	// [RULE6] set code by selected cache
	chk_set_count: assert property (seq_read(cir_pkg::CIR_REG_SIZE) |=> // [RULE6]
		acc_rdata_o[27:13] == ($past(cur_sel) ? cir_pkg::cir_set_code(ICACHE_KB) :
		cir_pkg::cir_set_code(DCACHE_KB)))
		else $error("set count field wrong");

	// [RULE7] [RULE8] fixed geometry
	chk_way_line: assert property (seq_read(cir_pkg::CIR_REG_SIZE) |=> // [RULE7]
		acc_rdata_o[12:0] == 13'h0019)
		else $error("associativity or line field wrong");

	// [RULE12] constant level word
	chk_level_word: assert property (seq_read(cir_pkg::CIR_REG_LEVEL) |=> // [RULE12]
		seq_good_answer ##0 acc_rdata_o == 32'h09200003)
		else $error("cache level word wrong");

	// [RULE13] auxiliary reads zero
	chk_aux_zero: assert property (seq_read(cir_pkg::CIR_REG_AUX) |=> // [RULE13]
		seq_good_answer ##0 acc_rdata_o == 32'h00000000)
		else $error("auxiliary word not zero");

	// [RULE14] selection reads only bit zero
	chk_sel_readback: assert property (seq_read(cir_pkg::CIR_REG_SELECT) |=> // [RULE14]
		acc_rdata_o[31:1] == 31'h00000000 && acc_rdata_o[0] == $past(cur_sel))
		else $error("selection read back wrong");

	// [RULE15] written bit is retained and reported
	chk_sel_retain: assert property (seq_write_read |=> // [RULE15]
		acc_rdata_o[0] == $past(acc_wdata_i[0], 2))
		else $error("selection bit not retained");

	// [RULE16] secure write leaves non-secure copy alone
	chk_bank_split: assert property (seq_sel_write and acc_secure_i |=> // [RULE16]
		sel_nonsec == $past(sel_nonsec))
		else $error("non-secure copy disturbed");

	// [RULE20] unprivileged access refused
	chk_unpriv_undef: assert property (acc_valid_i && !acc_priv_i |=> // [RULE20]
		acc_done_o && acc_undef_o && acc_rdata_o == 32'h00000000 &&
		$stable(sel_secure) && $stable(sel_nonsec))
		else $error("unprivileged access not refused");

	// [RULE19] write to identification register refused
	chk_ro_write: assert property (acc_valid_i && acc_write_i && target != cir_pkg::CIR_REG_SELECT |=> // [RULE19]
		acc_undef_o)
		else $error("read-only register took a write");

	// Answer is a single pulse per access
	chk_done_pulse: assert property (!acc_valid_i |=> !acc_done_o && !acc_undef_o)
		else $error("answer without access");

	// [RULE2] [RULE4] no write-through, read-allocation always
	chk_caps_fixed: assert property (seq_read(cir_pkg::CIR_REG_SIZE) |=> // [RULE2] [RULE4]
		!acc_rdata_o[31] && acc_rdata_o[29])
		else $error("fixed capability bits wrong");

	// [RULE3] [RULE5] write-back and write-allocation on data only
	chk_caps_alloc: assert property (seq_read(cir_pkg::CIR_REG_SIZE) |=> // [RULE3] [RULE5]
		acc_rdata_o[30] == !$past(cur_sel) && acc_rdata_o[28] == !$past(cur_sel))
		else $error("data-only capability bits wrong");

	// [RULE11] level fields and reserved bits
	chk_level_fields: assert property (seq_read(cir_pkg::CIR_REG_LEVEL) |=> // [RULE11]
		acc_rdata_o[29:27] == 3'h1 && acc_rdata_o[26:24] == 3'h1 &&
		acc_rdata_o[23:21] == 3'h1 && acc_rdata_o[31:30] == 2'h0)
		else $error("level fields wrong");

	// [RULE16] non-secure write leaves secure copy alone
	chk_bank_split_ns: assert property (seq_sel_write and !acc_secure_i |=> // [RULE16]
		sel_secure == $past(sel_secure))
		else $error("secure copy disturbed");

	// [RULE15] write lands in the copy of its state
	chk_sel_lands: assert property (seq_sel_write |=> // [RULE15]
		($past(acc_secure_i) ? sel_secure : sel_nonsec) == $past(acc_wdata_i[0]))
		else $error("selection write lost");

	// ==========================================================
	// Assertions on the selection copies, refusals and answers
	// ==========================================================
	// [RULE15] copies hold without a write
	chk_sel_hold: assert property (!sel_wr_en |=> // [RULE15]
		$stable(sel_secure) && $stable(sel_nonsec))
		else $error("selection copy moved without write");

	// [RULE19] refused identification write changes nothing
	chk_ro_keep: assert property (acc_valid_i && acc_write_i && target != cir_pkg::CIR_REG_SELECT |=> // [RULE19]
		$stable(sel_secure) && $stable(sel_nonsec))
		else $error("read-only write changed a copy");

	// [RULE19] selection write answers without data
	chk_write_answer: assert property (seq_sel_write |=> // [RULE19]
		seq_good_answer ##0 acc_rdata_o == 32'h00000000)
		else $error("selection write answer wrong");

	// [RULE18] privileged known read is answered
	chk_priv_known: assert property (acc_valid_i && acc_priv_i && !acc_write_i && // [RULE18]
		target != cir_pkg::CIR_REG_NONE |=> acc_done_o && !acc_undef_o)
		else $error("privileged read refused");

	// [RULE20] unknown selectors refused
	chk_unmapped_undef: assert property (acc_valid_i && target == cir_pkg::CIR_REG_NONE |=> // [RULE20]
		acc_done_o && acc_undef_o)
		else $error("unknown selector not refused");

	// [RULE20] refusal carries no data
	chk_undef_data: assert property (acc_undef_o |-> // [RULE20]
		acc_done_o && acc_rdata_o == 32'h00000000)
		else $error("refusal carried data");

	// Data is zero between answers
	chk_idle_data: assert property (!acc_valid_i |=> acc_rdata_o == 32'h00000000)
		else $error("data without access");

	// Reset clears the answer and both copies
	chk_reset_clear: assert property (disable iff (1'b0) srst_i |=>
		!acc_done_o && !acc_undef_o && acc_rdata_o == 32'h00000000 &&
		!sel_secure && !sel_nonsec)
		else $error("reset left state behind");

endmodule

/* File: logic/cir_pkg.sv */
package cir_pkg;

	// ==========================================================
	// Access selectors
	// ==========================================================
	localparam logic [2:0] CIR_OPC1_IDENT = 3'h1;
	localparam logic [2:0] CIR_OPC1_SELECT = 3'h2;
	localparam logic [3:0] CIR_CRN_ZERO = 4'h0;
	localparam logic [3:0] CIR_CRM_ZERO = 4'h0;
	localparam logic [2:0] CIR_OPC2_SIZE = 3'h0;
	localparam logic [2:0] CIR_OPC2_LEVEL = 3'h1;
	localparam logic [2:0] CIR_OPC2_AUX = 3'h7;
	localparam logic [2:0] CIR_OPC2_SELECT = 3'h0;

	// ==========================================================
	// Size identification fields
	// ==========================================================
	localparam logic [3:0] CIR_CAPS_INSTR = 4'h2;
	localparam logic [3:0] CIR_CAPS_DATA = 4'h7;
	localparam logic [14:0] CIR_SETS_16KB = 15'h007f;
	localparam logic [14:0] CIR_SETS_32KB = 15'h00ff;
	localparam logic [14:0] CIR_SETS_64KB = 15'h01ff;
	localparam logic [9:0] CIR_ASSOC_FOUR_WAYS = 10'h003;
	localparam logic [2:0] CIR_LINE_EIGHT_WORDS = 3'h1;
	localparam int CIR_DEFAULT_CACHE_KB = 32;

	// ==========================================================
	// Cache level identification value
	// ==========================================================
	localparam logic [1:0] CIR_LEVEL_RSVD = 2'h0;
	localparam logic [2:0] CIR_UNIFY_LEVEL = 3'h1;
	localparam logic [2:0] CIR_COHERENCY_LEVEL = 3'h1;
	localparam logic [2:0] CIR_INNER_UNIFY_LEVEL = 3'h1;
	localparam logic [17:0] CIR_UPPER_LEVELS_NONE = 18'h00000;
	localparam logic [2:0] CIR_L1_SPLIT = 3'h3;
	localparam logic [31:0] CIR_LEVEL_ID_VALUE = {CIR_LEVEL_RSVD, CIR_UNIFY_LEVEL, CIR_COHERENCY_LEVEL,
		CIR_INNER_UNIFY_LEVEL, CIR_UPPER_LEVELS_NONE, CIR_L1_SPLIT};

	// ==========================================================
	// Other values
	// ==========================================================
	localparam logic [31:0] CIR_AUX_ID_VALUE = 32'h00000000;
	localparam logic CIR_SELECT_RESET = 1'h0;
	localparam int CIR_SELECT_BIT = 0;

	// Target register of an access
	typedef enum {
		CIR_REG_NONE,
		CIR_REG_SIZE,
		CIR_REG_LEVEL,
		CIR_REG_AUX,
		CIR_REG_SELECT
	} cir_reg_t;

	// Decodes the coprocessor selectors into a register
	function automatic cir_reg_t cir_decode(input logic [2:0] opc1, input logic [3:0] crn,
		input logic [3:0] crm, input logic [2:0] opc2);
		cir_reg_t r;
		r = CIR_REG_NONE;
		if (crn == CIR_CRN_ZERO && crm == CIR_CRM_ZERO) begin
			if (opc1 == CIR_OPC1_IDENT && opc2 == CIR_OPC2_SIZE) begin
				r = CIR_REG_SIZE;
			end else if (opc1 == CIR_OPC1_IDENT && opc2 == CIR_OPC2_LEVEL) begin
				r = CIR_REG_LEVEL;
			end else if (opc1 == CIR_OPC1_IDENT && opc2 == CIR_OPC2_AUX) begin
				r = CIR_REG_AUX;
			end else if (opc1 == CIR_OPC1_SELECT && opc2 == CIR_OPC2_SELECT) begin
				r = CIR_REG_SELECT;
			end
		end
		return r;
	endfunction

	// Set count code for a configured cache size
	function automatic logic [14:0] cir_set_code(input int size_kb);
		logic [14:0] c;
		c = CIR_SETS_32KB;
		if (size_kb == 16) begin
			c = CIR_SETS_16KB;
		end else if (size_kb == 64) begin
			c = CIR_SETS_64KB;
		end
		return c;
	endfunction

endpackage

/* File: logic/cir_select_bank.sv */
`timescale 1ns/10ps
// Banked copies of the cache selection bit, one per security state
module cir_select_bank (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic wr_en_i,
	input wire logic secure_i,
	input wire logic wr_sel_i,
	output logic sel_secure_o,
	output logic sel_nonsec_o,
	output logic cur_sel_o
);

	logic next_sel_secure;
	logic next_sel_nonsec;

	// ==========================================================
	// Next value of each copy
	// ==========================================================
	always_comb begin
		next_sel_secure = sel_secure_o;
		next_sel_nonsec = sel_nonsec_o;
		if (wr_en_i && secure_i) begin
			next_sel_secure = wr_sel_i;
		end
		if (wr_en_i && !secure_i) begin
			next_sel_nonsec = wr_sel_i;
		end
	end

	// Copy registers
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sel_secure_o <= cir_pkg::CIR_SELECT_RESET;
			sel_nonsec_o <= cir_pkg::CIR_SELECT_RESET;
		end else begin
			sel_secure_o <= next_sel_secure;
			sel_nonsec_o <= next_sel_nonsec;
		end
	end

	// Copy of the current security state
	assign cur_sel_o = secure_i ? sel_secure_o : sel_nonsec_o;

endmodule

/* File: logic/cir_size_encode.sv */
`timescale 1ns/10ps
// Builds the size identification word of the selected cache
module cir_size_encode #(
	parameter int ICACHE_KB = cir_pkg::CIR_DEFAULT_CACHE_KB,
	parameter int DCACHE_KB = cir_pkg::CIR_DEFAULT_CACHE_KB
) (
	input wire logic instr_sel_i,
	output logic [31:0] size_id_o
);

	logic [3:0] caps;
	logic [14:0] sets;

	// ==========================================================
	// Capability and geometry fields
	// ==========================================================
	always_comb begin
		// [RULE2] [RULE3] [RULE4] [RULE5] [RULE9] [RULE10] capability nibble
		caps = instr_sel_i ? cir_pkg::CIR_CAPS_INSTR : cir_pkg::CIR_CAPS_DATA;
		// [RULE6] set count code
		sets = instr_sel_i ? cir_pkg::cir_set_code(ICACHE_KB) : cir_pkg::cir_set_code(DCACHE_KB);
		// [RULE7] [RULE8] fixed geometry fields
		size_id_o = {caps, sets, cir_pkg::CIR_ASSOC_FOUR_WAYS, cir_pkg::CIR_LINE_EIGHT_WORDS};
	end

endmodule

/* File: sim/cir_cache_ident_bench.sv */
`timescale 1ns/10ps
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
	$display("MISMATCH %s expected %h seen %h", what, exp, got); end end
module cir_cache_ident_bench;
	// ==========================================================
	// Setup
	// ==========================================================
	localparam int IKB = 16;
	localparam int DKB = 64;
	localparam int MAX_CYCLES = 20000;
	logic clk_i, srst_i, acc_valid_i, acc_write_i, acc_priv_i, acc_secure_i;
	logic [2:0] acc_opc1_i, acc_opc2_i;
	logic [3:0] acc_crn_i, acc_crm_i;
	logic [31:0] acc_wdata_i;
	logic acc_done_o, acc_undef_o;
	logic [31:0] acc_rdata_o;
	logic [1:0] sel; // Selection bit per state, index 1 is Secure
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;

	cir_cache_ident #(.ICACHE_KB(IKB), .DCACHE_KB(DKB)) u_cir_cache_ident (.clk_i(clk_i), .srst_i(srst_i),
		.acc_valid_i(acc_valid_i), .acc_write_i(acc_write_i), .acc_opc1_i(acc_opc1_i), .acc_crn_i(acc_crn_i),
		.acc_crm_i(acc_crm_i), .acc_opc2_i(acc_opc2_i), .acc_wdata_i(acc_wdata_i), .acc_priv_i(acc_priv_i),
		.acc_secure_i(acc_secure_i), .acc_done_o(acc_done_o), .acc_undef_o(acc_undef_o),
		.acc_rdata_o(acc_rdata_o));

	// Clock and hang guard
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles >= MAX_CYCLES) begin
			miscompares++;
			give_verdict();
		end
	end

	// ==========================================================
	// Expectations
	// ==========================================================
	function automatic logic [14:0] sets_for(input int kb);
		return (kb == 16) ? 15'h007f : (kb == 64) ? 15'h01ff : 15'h00ff;
	endfunction
	function automatic logic [31:0] size_word(input logic instr);
		return instr ? {4'h2, sets_for(IKB), 10'h003, 3'h1} : {4'h7, sets_for(DKB), 10'h003, 3'h1};
	endfunction

	// ==========================================================
	// Tasks
	// ==========================================================
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic do_reset(input int n);
		@(posedge clk_i);
		srst_i <= 1'b1;
		repeat (n) @(posedge clk_i);
		srst_i <= 1'b0;
		sel = 2'b00;
		@(posedge clk_i);
	endtask

	// Kind: 0 write sel, 1 read sel, 2 size, 3 level, 4 aux, 5 bad crn/crm, 6 bad opc2
	task automatic op(input int kind, input logic wr, input logic pv, input logic sc, input logic [31:0] wd);
		logic [2:0] o1, o2;
		logic [3:0] cn, cm;
		logic eu;
		logic [31:0] er;
		o1 = (kind <= 1) ? 3'h2 : 3'h1;
		o2 = (kind == 3) ? 3'h1 : (kind == 4) ? 3'h7 : (kind == 6) ? 3'($urandom_range(2, 6)) : 3'h0;
		cn = (kind == 5) ? 4'($urandom_range(0, 15)) : 4'h0;
		cm = (kind == 5 && cn == 4'h0) ? 4'($urandom_range(1, 15)) : 4'h0;
		eu = !pv || kind >= 5 || (wr && kind >= 2);
		er = 32'h00000000;
		if (!eu) begin
			case (kind)
				1: er = {31'h0, sel[sc]};
				2: er = size_word(sel[sc]);
				3: er = {2'h0, 3'h1, 3'h1, 3'h1, 18'h00000, 3'h3};
				default: er = 32'h00000000;
			endcase
		end
		@(posedge clk_i);
		acc_valid_i <= 1'b1;
		acc_write_i <= wr;
		acc_opc1_i <= o1;
		acc_opc2_i <= o2;
		acc_crn_i <= cn;
		acc_crm_i <= cm;
		acc_wdata_i <= wd;
		acc_priv_i <= pv;
		acc_secure_i <= sc;
		@(posedge clk_i);
		acc_valid_i <= 1'b0;
		acc_priv_i <= 1'($urandom_range(0, 1));
		acc_secure_i <= 1'($urandom_range(0, 1));
		acc_wdata_i <= $urandom;
		#1;
		// Answer one cycle later
		`CHK("done", 1'b1, acc_done_o)
		`CHK("undef", eu, acc_undef_o)
		`CHK("rdata", er, acc_rdata_o)
		if (kind == 0 && wr && !eu) begin
			sel[sc] = wd[0];
		end
		@(posedge clk_i);
		#1;
		`CHK("done low", 1'b0, acc_done_o)
		`CHK("rdata idle", 32'h00000000, acc_rdata_o)
	endtask

	// Selection write and read of the same state on back-to-back cycles
	task automatic wr_rd(input logic sc, input logic [31:0] wd);
		@(posedge clk_i);
		acc_valid_i <= 1'b1;
		acc_write_i <= 1'b1;
		acc_opc1_i <= 3'h2;
		acc_opc2_i <= 3'h0;
		acc_crn_i <= 4'h0;
		acc_crm_i <= 4'h0;
		acc_wdata_i <= wd;
		acc_priv_i <= 1'b1;
		acc_secure_i <= sc;
		@(posedge clk_i);
		acc_write_i <= 1'b0;
		acc_wdata_i <= ~wd;
		sel[sc] = wd[0];
		#1;
		`CHK("b2b write undef", 1'b0, acc_undef_o)
		@(posedge clk_i);
		acc_valid_i <= 1'b0;
		#1;
		`CHK("b2b read", 32'(sel[sc]), acc_rdata_o)
	endtask

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		logic [31:0] w;
		int k;
		srst_i = 1'b1;
		acc_valid_i = 1'b0;
		acc_write_i = 1'b0;
		acc_opc1_i = 3'h0;
		acc_opc2_i = 3'h0;
		acc_crn_i = 4'h0;
		acc_crm_i = 4'h0;
		acc_wdata_i = 32'h00000000;
		acc_priv_i = 1'b0;
		acc_secure_i = 1'b0;
		sel = 2'b00;
		void'($urandom(32'haf00));
		do_reset(10);
		// Reset state and shared identification values
		for (int s = 0; s < 2; s++) begin
			op(1, 1'b0, 1'b1, s[0], 32'h0);
			op(2, 1'b0, 1'b1, s[0], 32'h0);
			op(3, 1'b0, 1'b1, s[0], 32'h0);
			op(4, 1'b0, 1'b1, s[0], 32'h0);
		end
		// Secure copy to instruction cache, upper bits all ones
		op(0, 1'b1, 1'b1, 1'b1, 32'hffffffff);
		op(1, 1'b0, 1'b1, 1'b1, 32'h0);
		op(1, 1'b0, 1'b1, 1'b0, 32'h0);
		op(2, 1'b0, 1'b1, 1'b1, 32'h0);
		op(2, 1'b0, 1'b1, 1'b0, 32'h0);
		// Unprivileged write must not change the Secure copy
		op(0, 1'b1, 1'b0, 1'b1, 32'h00000000);
		op(1, 1'b0, 1'b1, 1'b1, 32'h0);
		// Writes to read-only registers and reads of unknown selectors are refused
		for (int r = 2; r <= 4; r++) begin
			op(r, 1'b1, 1'b1, 1'b0, $urandom);
		end
		op(5, 1'b0, 1'b1, 1'b0, 32'h0);
		op(6, 1'b0, 1'b1, 1'b1, 32'h0);
		// Read right after write returns the new bit
		wr_rd(1'b0, 32'h00000001);
		wr_rd(1'b0, 32'hfffffffe);
		// Mid-run reset returns both copies to data cache
		do_reset(2);
		op(2, 1'b0, 1'b1, 1'b1, 32'h0);
		// Random traffic
		repeat (300) begin
			k = $urandom_range(0, 7);
			w = $urandom;
			if (k == 7) begin
				wr_rd(1'($urandom_range(0, 1)), w);
			end else begin
				op(k, (k == 0) ? 1'b1 : (k == 1) ? 1'b0 : ($urandom_range(0, 3) == 0), $urandom_range(0, 7) != 0,
					1'($urandom_range(0, 1)), w);
			end
		end
		give_verdict();
	end
endmodule
